// ### common/rtcsa_pkg.sv
`default_nettype none
package rtcsa_pkg;

  // register offsets on the device register port
  localparam logic [3:0] TRIM_OFS  = 4'h7;
  localparam logic [3:0] INTEN_OFS = 4'hE;
  localparam logic [3:0] FLAG_OFS  = 4'hF;

  // interrupt_enable_control fields
  localparam int WK_EN_BIT    = 7;
  localparam int DY_EN_BIT    = 6;
  localparam int HOUR12_BIT   = 5;
  localparam int SCLK_B_BIT   = 4;
  localparam int TEST_BIT     = 3;
  localparam int PER_SEL_LSB  = 0;

  // flag_status_control fields
  localparam int THR_SEL_BIT  = 7;
  localparam int DROP_BIT     = 6;
  localparam int SPARE_BIT    = 5;
  localparam int HALT_BIT     = 4;
  localparam int SCLK_A_BIT   = 3;
  localparam int PER_FLAG_BIT = 2;
  localparam int WK_FLAG_BIT  = 1;
  localparam int DY_FLAG_BIT  = 0;

  // values held after power-up and after a halt event
  localparam logic [7:0] INTEN_RST = 8'h00;
  localparam logic [6:0] TRIM_RST  = 7'h00;
  localparam logic       HALT_RST  = 1'b1;

  // time base: sub-clock ticks per nominal second, correction window, step
  localparam logic [15:0] SUB_PER_SEC   = 16'h8000;
  localparam logic [4:0]  TRIM_WIN_SEC  = 5'h14;
  localparam int          TRIM_STEP_SH  = 1;

  // supply sampling window
  localparam int SAMPLE_WIN_NS  = 7800000;
  localparam int CLK_PERIOD_NS  = 4;
  localparam int SAMPLE_CYCLES  = (SAMPLE_WIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SAMPLE_CNT_W   = 21;

  typedef enum logic [2:0] {
    PER_OFF, PER_LOW, PER_2HZ, PER_1HZ, PER_SEC, PER_MIN, PER_HOUR, PER_MONTH
  } rtcsa_per_mode_t;

  typedef enum logic {MON_WAIT, MON_SAMPLE} rtcsa_mon_state_t;

  // length of the corrected second in sub-clock ticks
  function automatic logic [15:0] trim_len(input logic [6:0] code);
    logic [15:0] ext;
    ext = {9'h000, code};
    if (code == 7'h00 || code == 7'h01 || code == 7'h40 || code == 7'h41) begin
      trim_len = SUB_PER_SEC;
    end else if (!code[6]) begin
      trim_len = SUB_PER_SEC + ((ext - 16'h0001) << TRIM_STEP_SH);
    end else begin
      trim_len = SUB_PER_SEC - ((16'h0080 - ext) << TRIM_STEP_SH);
    end
  endfunction

  // hour and minute comparison shared by both alarms
  function automatic logic hm_match(input logic [7:0] h_a, input logic [7:0] m_a,
                                    input logic [7:0] h_b, input logic [7:0] m_b);
    hm_match = (h_a == h_b) && (m_a == m_b);
  endfunction

endpackage
`default_nettype wire

// ### common/rtcsa_tick_if.sv
`timescale 1ns/1ps
`default_nettype none
interface rtcsa_tick_if;
  logic       sub_tick;
  logic [6:0] trim_code;
  logic       sec_tick;
  logic [1:0] frac;
  modport gen  (input sub_tick, input trim_code, output sec_tick, output frac);
  modport core (output sub_tick, output trim_code, input sec_tick, input frac);
endinterface
`default_nettype wire

// ### rtl/rtcsa_core.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Sub-clock output follows the raw oscillator; trimming never touches it.
// - Codes 0000010..0111111 slow the time count by 3.05 to 189.2 ppm.
// - Codes 1111111..1000010 speed the time count by 3.05 to 189.2 ppm.
// - Threshold select 0 compares against 2.1 V, 1 against 1.6 V.
// - Halt and supply-drop flags set on event, hold until written 0.
// - Halt flag becoming 1 forces supply-drop flag to 0.
// - Halt detection only while chip enable is low; result kept afterwards.
// - Halt clears trim, enables, mode, clock enables, test, select, spare, flags.
// - Power-up with chip enable low sets the halt flag, clearing dependents.
// - Power-up with chip enable high also sets the halt flag; the undefined state is not modelled.
// - Supply is sampled only in a 7.8 ms window each second.
// - Sampling stops while the supply-drop flag is 1.
// - Alarm match drives interrupt low; week alarm adds day-of-week.
// - Week flag at bit 1 of flag register, enable at bit 7.
// - Daily flag at bit 0 of flag register, enable at bit 6.
// - Periodic select at bits 2..0, zero disables; flag at bit 2.
// - With all enables and selects zero the interrupt is released.
// - Interrupt is low while any source asserts.
// - Each alarm works only while its enable is 1.
// - Alarm flag reads status; write 1 ignored, write 0 clears and releases.
// - Clearing an alarm flag leaves its enable alone.
// - Level mode drives low each period until its flag is written 0.
// - Trimming changes the tick count of one second every 20 seconds.
module rtcsa_core #(
  parameter int SAMPLE_CYCLES = rtcsa_pkg::SAMPLE_CYCLES  // supply sampling window length
) (
  input  wire logic       mclk,            // system clock, 250 MHz
  input  wire logic       reset_n,         // synchronous reset, active low
  input  wire logic       ce,              // chip enable pin level
  input  wire logic       osc_stopped,     // oscillator halt sensor level
  input  wire logic       sub_tick,        // one pulse per sub-clock period
  input  wire logic       subclock_in,     // raw sub-clock level
  input  wire logic       clkc,            // sub-clock output control pin
  input  wire logic       below_2v1,       // supply under high threshold
  input  wire logic       below_1v6,       // supply under low threshold
  input  wire logic [3:0] reg_addr,        // register offset
  input  wire logic       reg_wr,          // register write strobe
  input  wire logic [7:0] reg_wdata,       // register write data
  input  wire logic [2:0] cur_weekday,     // current day of week 0..6
  input  wire logic [7:0] cur_hour,        // current hour
  input  wire logic [7:0] cur_minute,      // current minute
  input  wire logic [6:0] wk_alarm_days,   // week alarm day mask
  input  wire logic [7:0] wk_alarm_hour,   // week alarm hour
  input  wire logic [7:0] wk_alarm_minute, // week alarm minute
  input  wire logic [7:0] dy_alarm_hour,   // daily alarm hour
  input  wire logic [7:0] dy_alarm_minute, // daily alarm minute
  input  wire logic       minute_tick,     // minute rollover pulse
  input  wire logic       hour_tick,       // hour rollover pulse
  input  wire logic       month_tick,      // month rollover pulse
  output logic      [7:0] reg_rdata,       // registered read data
  output logic            sec_tick,        // corrected one-second pulse
  output logic            hour_mode_12,    // 12/24 selector to the counters
  output logic            test_mode,       // test bit
  output logic            irq_n_out,       // interrupt pin output value
  output logic            irq_n_out_oe,    // interrupt pin drive enable
  output logic            subclock_out     // sub-clock output pin
);

  logic [6:0] trim_q;
  logic       wk_en_q;
  logic       dy_en_q;
  logic       hour12_q;
  logic       sclk_b_q;
  logic       test_q;
  logic [2:0] per_sel_q;
  logic       thr_sel_q;
  logic       drop_q;
  logic       spare_q;
  logic       halt_q;
  logic       sclk_a_q;
  logic       per_flag_q;
  logic       wk_flag_q;
  logic       dy_flag_q;
  logic       wk_match_q;
  logic       dy_match_q;
  logic       irq_low_q;
  logic       sclk_out_q;
  logic [7:0] rdata_q;

  logic       wr_trim;
  logic       wr_inten;
  logic       wr_flag;
  logic       halt_evt;
  logic       wk_match;
  logic       dy_match;
  logic       wk_set;
  logic       dy_set;
  logic       per_evt;
  logic       per_drive;
  logic       drop_evt;
  logic       under;
  rtcsa_pkg::rtcsa_per_mode_t per_mode;

  rtcsa_pkg::rtcsa_mon_state_t mon_q;
  logic [rtcsa_pkg::SAMPLE_CNT_W-1:0] win_cnt_q;

  // last count of the sampling window, cut to the counter width
  localparam int WIN_LAST = SAMPLE_CYCLES - 1;

  rtcsa_tick_if tick ();

  assign tick.sub_tick  = sub_tick;
  assign tick.trim_code = trim_q;

  rtcsa_sec_gen u_sec_gen (
    .mclk    (mclk),
    .reset_n (reset_n),
    .t       (tick)
  );

  assign wr_trim  = reg_wr && (reg_addr == rtcsa_pkg::TRIM_OFS);
  assign wr_inten = reg_wr && (reg_addr == rtcsa_pkg::INTEN_OFS);
  assign wr_flag  = reg_wr && (reg_addr == rtcsa_pkg::FLAG_OFS);

  // sensing gated by chip enable low
  assign halt_evt = osc_stopped && !ce;

  // halt clears win over any write in the same cycle
  // trim cleared on halt
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      trim_q <= rtcsa_pkg::TRIM_RST;
    end else if (halt_evt) begin
      trim_q <= rtcsa_pkg::TRIM_RST;
    end else if (wr_trim) begin
      trim_q <= reg_wdata[6:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n || halt_evt) begin
      wk_en_q   <= rtcsa_pkg::INTEN_RST[rtcsa_pkg::WK_EN_BIT];
      dy_en_q   <= rtcsa_pkg::INTEN_RST[rtcsa_pkg::DY_EN_BIT];
      hour12_q  <= rtcsa_pkg::INTEN_RST[rtcsa_pkg::HOUR12_BIT];
      sclk_b_q  <= rtcsa_pkg::INTEN_RST[rtcsa_pkg::SCLK_B_BIT];
      test_q    <= rtcsa_pkg::INTEN_RST[rtcsa_pkg::TEST_BIT];
      per_sel_q <= rtcsa_pkg::INTEN_RST[rtcsa_pkg::PER_SEL_LSB +: 3];
    end else if (wr_inten) begin
      wk_en_q   <= reg_wdata[rtcsa_pkg::WK_EN_BIT];
      dy_en_q   <= reg_wdata[rtcsa_pkg::DY_EN_BIT];
      hour12_q  <= reg_wdata[rtcsa_pkg::HOUR12_BIT];
      sclk_b_q  <= reg_wdata[rtcsa_pkg::SCLK_B_BIT];
      test_q    <= reg_wdata[rtcsa_pkg::TEST_BIT];
      per_sel_q <= reg_wdata[rtcsa_pkg::PER_SEL_LSB +: 3];
    end
  end

  // plain status bits cleared on halt
  always_ff @(posedge mclk) begin
    if (!reset_n || halt_evt) begin
      thr_sel_q <= 1'b0;
      spare_q   <= 1'b0;
      sclk_a_q  <= 1'b0;
    end else if (wr_flag) begin
      thr_sel_q <= reg_wdata[rtcsa_pkg::THR_SEL_BIT];
      spare_q   <= reg_wdata[rtcsa_pkg::SPARE_BIT];
      sclk_a_q  <= reg_wdata[rtcsa_pkg::SCLK_A_BIT];
    end
  end

  // sticky halt flag, only a write of 0 clears
  // undefined power-up not modelled, reset always sets
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      halt_q <= rtcsa_pkg::HALT_RST;
    end else if (halt_evt) begin
      halt_q <= 1'b1;
    end else if (wr_flag && !reg_wdata[rtcsa_pkg::HALT_BIT]) begin
      halt_q <= 1'b0;
    end
  end

  assign under = thr_sel_q ? below_1v6 : below_2v1;

  // no new window while drop is recorded
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      mon_q     <= rtcsa_pkg::MON_WAIT;
      win_cnt_q <= '0;
    end else begin
      case (mon_q)
        rtcsa_pkg::MON_WAIT: begin
          win_cnt_q <= '0;
          if (tick.sec_tick && !drop_q) begin
            mon_q <= rtcsa_pkg::MON_SAMPLE;
          end
        end
        rtcsa_pkg::MON_SAMPLE: begin
          if (drop_q || win_cnt_q == WIN_LAST[rtcsa_pkg::SAMPLE_CNT_W-1:0]) begin
            mon_q <= rtcsa_pkg::MON_WAIT;
          end else begin
            win_cnt_q <= win_cnt_q + 1'b1;
          end
        end
        default: begin
          mon_q <= rtcsa_pkg::MON_WAIT;
        end
      endcase
    end
  end

  assign drop_evt = (mon_q == rtcsa_pkg::MON_SAMPLE) && !drop_q && under;

  // halt forces the drop flag to 0
  // drop flag sticky, set wins over a write of 0
  always_ff @(posedge mclk) begin
    if (!reset_n || halt_evt) begin
      drop_q <= 1'b0;
    end else if (drop_evt) begin
      drop_q <= 1'b1;
    end else if (wr_flag && !reg_wdata[rtcsa_pkg::DROP_BIT]) begin
      drop_q <= 1'b0;
    end
  end

  // week alarm also compares day of week
  assign wk_match = wk_alarm_days[cur_weekday] &&
                    rtcsa_pkg::hm_match(cur_hour, cur_minute, wk_alarm_hour, wk_alarm_minute);
  assign dy_match = rtcsa_pkg::hm_match(cur_hour, cur_minute, dy_alarm_hour, dy_alarm_minute);

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      wk_match_q <= 1'b0;
      dy_match_q <= 1'b0;
    end else begin
      wk_match_q <= wk_match;
      dy_match_q <= dy_match;
    end
  end

  // only the start of a match fires, so a cleared flag waits for the next one
  // enable gates the alarm
  assign wk_set = wk_en_q && wk_match && !wk_match_q;
  assign dy_set = dy_en_q && dy_match && !dy_match_q;

  // write 0 clears, write 1 ignored, set wins
  always_ff @(posedge mclk) begin
    if (!reset_n || halt_evt) begin
      wk_flag_q <= 1'b0;
      dy_flag_q <= 1'b0;
    end else begin
      if (wk_set) begin
        wk_flag_q <= 1'b1;
      end else if (wr_flag && !reg_wdata[rtcsa_pkg::WK_FLAG_BIT]) begin
        wk_flag_q <= 1'b0;
      end
      if (dy_set) begin
        dy_flag_q <= 1'b1;
      end else if (wr_flag && !reg_wdata[rtcsa_pkg::DY_FLAG_BIT]) begin
        dy_flag_q <= 1'b0;
      end
    end
  end

  assign per_mode = rtcsa_pkg::rtcsa_per_mode_t'(per_sel_q);

  always_comb begin
    per_evt   = 1'b0;
    per_drive = 1'b0;
    case (per_mode)
      rtcsa_pkg::PER_OFF: begin
        per_evt   = 1'b0;
        per_drive = 1'b0;
      end
      rtcsa_pkg::PER_LOW: begin
        per_drive = 1'b1;
      end
      rtcsa_pkg::PER_2HZ: begin
        per_evt   = tick.sec_tick;
        per_drive = !tick.frac[0];
      end
      rtcsa_pkg::PER_1HZ: begin
        per_evt   = tick.sec_tick;
        per_drive = !tick.frac[1];
      end
      rtcsa_pkg::PER_SEC: begin
        per_evt   = tick.sec_tick;
        per_drive = per_flag_q;
      end
      rtcsa_pkg::PER_MIN: begin
        per_evt   = minute_tick;
        per_drive = per_flag_q;
      end
      rtcsa_pkg::PER_HOUR: begin
        per_evt   = hour_tick;
        per_drive = per_flag_q;
      end
      rtcsa_pkg::PER_MONTH: begin
        per_evt   = month_tick;
        per_drive = per_flag_q;
      end
      default: begin
        per_evt   = 1'b0;
        per_drive = 1'b0;
      end
    endcase
  end

  // level mode flag held until written 0
  always_ff @(posedge mclk) begin
    if (!reset_n || halt_evt) begin
      per_flag_q <= 1'b0;
    end else if (per_evt) begin
      per_flag_q <= 1'b1;
    end else if (wr_flag && !reg_wdata[rtcsa_pkg::PER_FLAG_BIT]) begin
      per_flag_q <= 1'b0;
    end
  end

  // any source pulls the pin low
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      irq_low_q <= 1'b0;
    end else begin
      irq_low_q <= (wk_en_q && wk_flag_q) || (dy_en_q && dy_flag_q) || per_drive;
    end
  end

  // raw oscillator passed through, trim never applied
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      sclk_out_q <= 1'b0;
    end else begin
      sclk_out_q <= clkc && (!sclk_a_q || !sclk_b_q) && subclock_in;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rdata_q <= 8'h00;
    end else begin
      case (reg_addr)
        rtcsa_pkg::TRIM_OFS:  rdata_q <= {1'b0, trim_q};
        rtcsa_pkg::INTEN_OFS: rdata_q <= {wk_en_q, dy_en_q, hour12_q, sclk_b_q,
                                          test_q, per_sel_q};
        rtcsa_pkg::FLAG_OFS:  rdata_q <= {thr_sel_q, drop_q, spare_q, halt_q,
                                          sclk_a_q, per_flag_q, wk_flag_q, dy_flag_q};
        default:              rdata_q <= 8'h00;
      endcase
    end
  end

  assign reg_rdata    = rdata_q;
  assign sec_tick     = tick.sec_tick;
  assign hour_mode_12 = hour12_q;
  assign test_mode    = test_q;
  assign irq_n_out    = 1'b0;
  assign irq_n_out_oe = irq_low_q;
  assign subclock_out = sclk_out_q;

endmodule
`default_nettype wire

// ### rtl/rtcsa_dummy_unused.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ### rtl/rtcsa_sec_gen.sv
`timescale 1ns/1ps
`default_nettype none
module rtcsa_sec_gen (
  input  wire logic   mclk,    // system clock
  input  wire logic   reset_n, // synchronous reset, active low
  rtcsa_tick_if.gen   t        // tick carrier to the core
);
  logic [15:0] count_q;
  logic [4:0]  sec_cnt_q;
  logic        sec_tick_q;
  logic [1:0]  frac_q;
  logic [15:0] len;

  always_comb begin
    if (sec_cnt_q == rtcsa_pkg::TRIM_WIN_SEC - 5'h01) begin
      len = rtcsa_pkg::trim_len(t.trim_code);
    end else begin
      len = rtcsa_pkg::SUB_PER_SEC;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      count_q    <= 16'h0000;
      sec_cnt_q  <= 5'h00;
      sec_tick_q <= 1'b0;
    end else begin
      sec_tick_q <= 1'b0;
      if (t.sub_tick) begin
        if (count_q >= len - 16'h0001) begin
          count_q    <= 16'h0000;
          sec_tick_q <= 1'b1;
          if (sec_cnt_q == rtcsa_pkg::TRIM_WIN_SEC - 5'h01) begin
            sec_cnt_q <= 5'h00;
          end else begin
            sec_cnt_q <= sec_cnt_q + 5'h01;
          end
        end else begin
          count_q <= count_q + 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      frac_q <= 2'h0;
    end else begin
      frac_q <= count_q[14:13];
    end
  end

  assign t.sec_tick = sec_tick_q;
  assign t.frac     = frac_q;
endmodule
`default_nettype wire

// ### tb/rtc_status_alarm_interrupt_test.sv
`timescale 1ns/1ps
`default_nettype none
module rtc_status_alarm_interrupt_test;
  typedef struct {logic [3:0] a; logic [7:0] w; logic [7:0] r;} rtcsa_row_t;
  localparam logic [3:0] FLG = rtcsa_pkg::FLAG_OFS;
  localparam logic [3:0] IEN = rtcsa_pkg::INTEN_OFS;
  rtcsa_row_t rows [4] = '{'{4'h7, 8'hC2, 8'h42}, '{4'hE, 8'h38, 8'h38},
                           '{4'hF, 8'h00, 8'h00}, '{4'hF, 8'hFF, 8'hA8}};
  logic       mclk = 1'b0, reset_n = 1'b0, ce = 1'b0, osc_stopped = 1'b0, sub_tick = 1'b0;
  logic       subclock_in = 1'b0, clkc = 1'b1, below_2v1 = 1'b0, below_1v6 = 1'b0;
  logic [2:0] cur_weekday = 3'h3, ticks = 3'h0;
  logic [7:0] cur_hour = 8'h12, cur_minute = 8'h29, al_hour = 8'h12, al_min = 8'h30, d;
  logic [6:0] wk_days = 7'h08;
  logic [3:0] reg_addr;
  logic       reg_wr, sec_tick, hour_mode_12, test_mode, irq_n_out, irq_n_out_oe;
  logic       subclock_out, irq_line;
  logic [7:0] reg_wdata, reg_rdata;
  int         num_errors = 0, check_count = 0, cyc = 0;

  always #2 mclk = ~mclk;
  always @(negedge mclk) subclock_in <= ~subclock_in;

  rtcsa_core #(.SAMPLE_CYCLES(8)) dut_u (.mclk(mclk), .reset_n(reset_n), .ce(ce),
    .osc_stopped(osc_stopped), .sub_tick(sub_tick), .subclock_in(subclock_in), .clkc(clkc),
    .below_2v1(below_2v1), .below_1v6(below_1v6), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .cur_weekday(cur_weekday), .cur_hour(cur_hour),
    .cur_minute(cur_minute), .wk_alarm_days(wk_days), .wk_alarm_hour(al_hour),
    .wk_alarm_minute(al_min), .dy_alarm_hour(al_hour), .dy_alarm_minute(al_min),
    .minute_tick(ticks[0]), .hour_tick(ticks[1]), .month_tick(ticks[2]),
    .reg_rdata(reg_rdata), .sec_tick(sec_tick), .hour_mode_12(hour_mode_12),
    .test_mode(test_mode), .irq_n_out(irq_n_out), .irq_n_out_oe(irq_n_out_oe),
    .subclock_out(subclock_out));
  rtcsa_host_model host_u (.mclk(mclk), .reg_rdata(reg_rdata), .irq_n_out(irq_n_out),
    .irq_n_out_oe(irq_n_out_oe), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .irq_line(irq_line));

  task automatic end_sim;
    if (num_errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
    host_u.rd(a, d);
    chk(d, exp);
  endtask
  // the alarm compare only fires on the rising match, so step away first
  task automatic hit;
    @(negedge mclk) cur_minute = 8'h29;
    @(negedge mclk) cur_minute = 8'h30;
    repeat (3) @(negedge mclk);
  endtask
  task automatic wait_sec;
    for (int i = 0; i < 40000; i++) begin
      @(negedge mclk);
      if (sec_tick === 1'b1) break;
      if (i == 39999) num_errors++;
    end
    repeat (20) @(negedge mclk);
  endtask
  // ceiling: two full seconds of sub-clock ticks plus the register scenarios
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 90000) begin
      num_errors++;
      end_sim();
    end
  end

  initial begin
    repeat (4) @(negedge mclk);
    reset_n = 1'b1;
    rdchk(FLG, 8'h10);
    rdchk(IEN, 8'h00);
    chk(8'(irq_line), 8'h01);
    for (int i = 0; i < 4; i++) begin
      host_u.wr(rows[i].a, rows[i].w);
      rdchk(rows[i].a, rows[i].r);
    end
    chk(8'({hour_mode_12, test_mode}), 8'h03);
    @(posedge mclk) #1 chk(8'(subclock_out), 8'h00);
    host_u.wr(IEN, 8'h28);
    repeat (2) @(posedge mclk);
    #1 chk(8'(subclock_out), 8'(subclock_in));
    @(negedge mclk) clkc = 1'b0;
    repeat (3) @(posedge mclk);
    #1 chk(8'(subclock_out), 8'h00);
    host_u.wr(IEN, 8'h00);
    host_u.wr(FLG, 8'h00);
    hit();
    chk(8'(irq_line), 8'h01);
    host_u.arm(8'h40);
    hit();
    chk(8'(irq_line), 8'h00);
    rdchk(FLG, 8'h01);
    host_u.wr(FLG, 8'h01);
    rdchk(FLG, 8'h01);
    host_u.wr(FLG, 8'h00);
    rdchk(FLG, 8'h00);
    chk(8'(irq_line), 8'h01);
    rdchk(IEN, 8'h40);
    host_u.arm(8'hC0);
    cur_weekday = 3'h4;
    hit();
    rdchk(FLG, 8'h01);
    host_u.wr(FLG, 8'h00);
    cur_weekday = 3'h3;
    hit();
    rdchk(FLG, 8'h03);
    host_u.wr(FLG, 8'h02);
    rdchk(FLG, 8'h02);
    chk(8'(irq_line), 8'h00);
    host_u.wr(FLG, 8'h00);
    host_u.wr(IEN, 8'h01);
    repeat (3) @(negedge mclk);
    chk(8'(irq_line), 8'h00);
    for (int m = 5; m < 8; m++) begin
      host_u.wr(IEN, 8'(m));
      @(negedge mclk) ticks = 3'h1 << (m - 5);
      @(negedge mclk) ticks = 3'h0;
      repeat (2) @(negedge mclk);
      chk(8'(irq_line), 8'h00);
      rdchk(FLG, 8'h04);
      host_u.wr(FLG, 8'h00);
      repeat (2) @(negedge mclk);
      chk(8'(irq_line), 8'h01);
    end
    host_u.wr(IEN, 8'h30);
    host_u.wr(4'h7, 8'h05);
    host_u.clr_drop(8'h80);
    below_2v1 = 1'b1;
    sub_tick = 1'b1;
    rdchk(FLG, 8'h80);
    wait_sec();
    rdchk(FLG, 8'h80);
    host_u.wr(FLG, 8'h00);
    wait_sec();
    below_2v1 = 1'b0;
    rdchk(FLG, 8'h40);
    ce = 1'b1;
    osc_stopped = 1'b1;
    rdchk(FLG, 8'h40);
    ce = 1'b0;
    rdchk(FLG, 8'h10);
    osc_stopped = 1'b0;
    ce = 1'b1;
    rdchk(IEN, 8'h00);
    rdchk(4'h7, 8'h00);
    rdchk(FLG, 8'h10);
    end_sim();
  end
endmodule
`default_nettype wire

// ### tb/rtcsa_core_checker.sv
`timescale 1ns/1ps
`default_nettype none
module rtcsa_core_checker #(
  parameter int SAMPLE_CYCLES = rtcsa_pkg::SAMPLE_CYCLES  // sampling window
) (
  input wire logic       mclk,         // clock
  input wire logic       reset_n,      // reset, active low
  input wire logic       ce,           // chip enable
  input wire logic       osc_stopped,  // halt sensor
  input wire logic       clkc,         // sub-clock control
  input wire logic [3:0] reg_addr,     // offset
  input wire logic       reg_wr,       // write strobe
  input wire logic [7:0] reg_wdata,    // write data
  input wire logic [7:0] reg_rdata,    // read data
  input wire logic       sec_tick,     // second pulse
  input wire logic       irq_n_out,    // open-drain value
  input wire logic       irq_n_out_oe, // open-drain enable
  input wire logic       subclock_out  // sub-clock pin
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  property p_rst_idle;
    disable iff (1'b0) !reset_n |=> !irq_n_out_oe && reg_rdata == 8'h00 && !sec_tick;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("outputs busy after reset");

  property p_halt_rd;
    $rose(reset_n) && reg_addr == rtcsa_pkg::FLAG_OFS && !reg_wr |=> reg_rdata == 8'h10;
  endproperty
  a_halt_rd: assert property (p_halt_rd) else $error("halt flag not set at power-up");

  property p_od_val;
    irq_n_out == 1'b0;
  endproperty
  a_od_val: assert property (p_od_val) else $error("interrupt pin value not low");

  property p_halt_oe;
    (osc_stopped && !ce) [*2] |=> !irq_n_out_oe;
  endproperty
  a_halt_oe: assert property (p_halt_oe) else $error("interrupt kept after halt");

  property p_sub_off;
    !clkc |=> !subclock_out;
  endproperty
  a_sub_off: assert property (p_sub_off) else $error("sub-clock runs with control low");

  property p_sec_one;
    sec_tick |=> !sec_tick;
  endproperty
  a_sec_one: assert property (p_sec_one) else $error("second pulse too long");

  // a clear that races a new match is not covered: the set would win
  property p_flag_clr;
    reg_wr && reg_addr == rtcsa_pkg::FLAG_OFS && !reg_wdata[0] && !osc_stopped
      ##1 reg_addr == rtcsa_pkg::FLAG_OFS |=> !reg_rdata[0];
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("daily flag not cleared");

  property p_per_low;
    reg_wr && reg_addr == rtcsa_pkg::INTEN_OFS && reg_wdata[2:0] == 3'h1 && !osc_stopped
      ##1 !osc_stopped && !(reg_wr && reg_addr == rtcsa_pkg::INTEN_OFS) |=> irq_n_out_oe;
  endproperty
  a_per_low: assert property (p_per_low) else $error("fixed-low select not driving");

  property p_dis_rel;
    reg_wr && reg_addr == rtcsa_pkg::INTEN_OFS && reg_wdata == 8'h00 |-> ##2 !irq_n_out_oe;
  endproperty
  a_dis_rel: assert property (p_dis_rel) else $error("disabled source still drives");

  c_irq: cover property ($rose(irq_n_out_oe) ##[1:200] !irq_n_out_oe);
  c_sec: cover property (sec_tick);
  c_halt: cover property (osc_stopped && !ce);
endmodule

bind rtcsa_core rtcsa_core_checker #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) chk_u (.mclk(mclk),
  .reset_n(reset_n), .ce(ce), .osc_stopped(osc_stopped), .clkc(clkc), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sec_tick(sec_tick),
  .irq_n_out(irq_n_out), .irq_n_out_oe(irq_n_out_oe), .subclock_out(subclock_out));
`default_nettype wire

// ### tb/rtcsa_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module rtcsa_host_model (
  input  wire logic       mclk,         // clock
  input  wire logic [7:0] reg_rdata,    // read data
  input  wire logic       irq_n_out,    // open-drain value
  input  wire logic       irq_n_out_oe, // open-drain enable
  output logic      [3:0] reg_addr,     // offset
  output logic            reg_wr,       // write strobe
  output logic      [7:0] reg_wdata,    // write data
  output wire logic       irq_line      // wire with pull-up
);
  // pull-up wins whenever the device lets go of the line
  assign irq_line = irq_n_out_oe ? irq_n_out : 1'b1;
  initial begin
    // flag register addressed from the start so the power-up read is seen at once
    reg_addr = rtcsa_pkg::FLAG_OFS;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
    // released data is scrambled so stale values cannot look valid
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    repeat (2) @(negedge mclk);
    d = reg_rdata;
  endtask
  task automatic arm(input logic [7:0] en);
    wr(rtcsa_pkg::INTEN_OFS, 8'h00);
    wr(rtcsa_pkg::INTEN_OFS, en);
  endtask
  task automatic clr_drop(input logic [7:0] keep);
    wr(rtcsa_pkg::FLAG_OFS, keep & 8'hBF);
  endtask
endmodule
`default_nettype wire
